// ===== rtl/pmfw_pkg.sv
// package of offsets, fields and timing for the page-mode flash write controller
package pmfw_pkg;
   // register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_PAGE = 8'h04;
   localparam logic [7:0] OFF_LOAD = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_READ = 8'h10;
   // control register bits
   localparam int CTRL_GO_WRITE = 0;
   localparam int CTRL_GO_ERASE = 1;
   localparam int CTRL_GO_UNPROT = 2;
   localparam int CTRL_USE_PROT = 3;
   // status register bits
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_FAIL = 2;
   localparam int STAT_PROT = 3;
   localparam int STAT_RDATA = 16;
   // geometry
   localparam int PAGE_BYTES = 128;
   localparam int PROT_LEN = 3;
   localparam int LONG_LEN = 6;
   localparam int CONFIRM_READS = 2;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   // timing, in ns, and derived clock counts
   localparam int CLK_NS = 40;
   localparam int BYTE_LOAD_WINDOW_NS = 100_000;
   localparam int BYTE_LOAD_TIMEOUT_NS = 200_000;
   localparam int T_GLITCH_NS = 5;
   localparam int T_WRITE_MAX_NS = 10_000_000;
   localparam int BLC_CYC = BYTE_LOAD_WINDOW_NS / CLK_NS;
   localparam int BLCO_CYC = (BYTE_LOAD_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
   localparam int GLITCH_CYC = (T_GLITCH_NS + CLK_NS - 1) / CLK_NS;
   localparam int WRITE_MAX_CYC = T_WRITE_MAX_NS / CLK_NS;
   // strobe cycle phases: address, strobe low, strobe low, strobe high, release
   localparam logic [2:0] PH_LAST = 3'h4;
   localparam logic [2:0] PH_SAMPLE = 3'h3;
   // controller states
   typedef enum logic [2:0] {
      PMFW_IDLE, PMFW_SEQ, PMFW_LOAD, PMFW_WAIT, PMFW_POLL, PMFW_RD
   } pmfw_state_t;
   // operations
   typedef enum logic [1:0] {
      PMFW_OP_WRITE, PMFW_OP_ERASE, PMFW_OP_UNPROT, PMFW_OP_READ
   } pmfw_op_t;
endpackage : pmfw_pkg

// ===== rtl/pmfw_ctrl.sv
// host-side controller that loads, writes, erases and polls a page-mode flash
//
// Function
// - optional protect prefix, byte loads, then timed write
// - one to 128 bytes per page load
// - only status reads while writing
// - every loaded byte shares one page address
// - next byte within 100 us keeps loading
// - confirm completion with two more reads
// - protected writes need prefix, unprotect six bytes
`timescale 1ns/1ps
`default_nettype none
module pmfw_ctrl
   import pmfw_pkg::*;
#(
   parameter int BLCO_WAIT = pmfw_pkg::BLCO_CYC + 16,
   parameter int WRITE_LIMIT = pmfw_pkg::WRITE_MAX_CYC,
   parameter logic [3*24-1:0] PROT_SEQ = 72'h0,
   parameter logic [6*24-1:0] UNPROT_SEQ = 144'h0,
   parameter logic [6*24-1:0] ERASE_SEQ = 144'h0
) (
   input wire logic clk, // 25 MHz clock
   input wire logic rst, // async reset, high
   input wire logic hsel, // slave select
   input wire logic [31:0] haddr, // byte address
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write when high
   input wire logic [2:0] hsize, // word only
   input wire logic [31:0] hwdata, // write data
   input wire logic hready, // bus ready
   output logic hreadyout, // always ready
   output logic [31:0] hrdata, // read data
   output logic hresp, // always okay
   output logic byte_space_select_n, // flash select, low active
   output logic wr_n, // flash write strobe
   output logic rd_n, // flash read strobe
   output logic [15:0] flash_addr, // flash address
   output logic [7:0] flash_dq_o, // data to flash
   output logic flash_dq_oe, // high while driving data
   input wire logic [7:0] flash_dq_i // data from flash
);
   import pmfw_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // bus slave
   logic wr_pend_q;
   logic [7:0] wr_off_q;
   logic [31:0] hrdata_q;
   logic use_prot_q;
   logic [8:0] page_q;
   logic busy_q;
   logic done_q;
   logic fail_q;
   logic prot_q;
   logic [7:0] rd_byte_q;
   logic [15:0] rd_addr_q;
   logic [7:0] buf_q [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] valid_q;
   pmfw_state_t state_q;
   pmfw_op_t op_q;

   // address-phase decode
   wire addr_ok = hsel && htrans[1] && hready;
   wire [31:0] stat_word = {8'h00, rd_byte_q, 12'h000, prot_q, fail_q, done_q, busy_q};
   wire [31:0] rd_mux = (haddr[7:0] == OFF_CTRL) ? {28'h000_0000, use_prot_q, 3'h0} :
                        (haddr[7:0] == OFF_PAGE) ? {23'h00_0000, page_q} :
                        (haddr[7:0] == OFF_STAT) ? stat_word :
                        (haddr[7:0] == OFF_READ) ? {16'h0000, rd_addr_q} : 32'h0000_0000;
   // data-phase write strobes, ignored while busy
   wire wr_fire = wr_pend_q && !busy_q;
   wire go_write = wr_fire && wr_off_q == OFF_CTRL && hwdata[CTRL_GO_WRITE];
   wire go_erase = wr_fire && wr_off_q == OFF_CTRL && hwdata[CTRL_GO_ERASE];
   wire go_unprot = wr_fire && wr_off_q == OFF_CTRL && hwdata[CTRL_GO_UNPROT];
   wire go_read = wr_fire && wr_off_q == OFF_READ;
   wire load_we = wr_fire && wr_off_q == OFF_LOAD;
   wire [6:0] load_idx = hwdata[6:0];

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_q;

   // address phase capture and read data
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wr_pend_q <= 1'b0;
         wr_off_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_off_q <= haddr[7:0];
            hrdata_q <= rd_mux;
         end
      end
   end

   // settings registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         use_prot_q <= 1'b0;
         page_q <= 9'h000;
         rd_addr_q <= 16'h0000;
      end else if (wr_fire) begin
         if (wr_off_q == OFF_CTRL) use_prot_q <= hwdata[CTRL_USE_PROT];
         if (wr_off_q == OFF_PAGE) page_q <= hwdata[8:0];
         if (wr_off_q == OFF_READ) rd_addr_q <= hwdata[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // page image: one generate entry per byte
   logic [6:0] idx_q;
   wire clr_buf = (state_q == PMFW_WAIT) && (op_q == PMFW_OP_WRITE);
   for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_buf
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            buf_q[g] <= ERASED_BYTE;
            valid_q[g] <= 1'b0;
         end else if (load_we && load_idx == 7'(g)) begin
            buf_q[g] <= hwdata[15:8];
            valid_q[g] <= 1'b1;
         end else if (clr_buf) begin
            valid_q[g] <= 1'b0; // unsent bytes are erased in the device
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer
   logic [2:0] ph_q;
   logic [2:0] seq_i_q;
   logic [19:0] tmr_q;
   logic [1:0] conf_q;
   logic tog_prev_q;
   logic have_prev_q;
   logic [15:0] last_addr_q;
   logic [7:0] last_data_q;

   // sequence entry selection
   wire [6*24-1:0] seq_vec = (op_q == PMFW_OP_ERASE) ? ERASE_SEQ :
                             (op_q == PMFW_OP_UNPROT) ? UNPROT_SEQ : {72'h0, PROT_SEQ};
   wire [2:0] seq_len = (op_q == PMFW_OP_WRITE) ? 3'(PROT_LEN) : 3'(LONG_LEN);
   wire [23:0] seq_ent = seq_vec[seq_i_q*24 +: 24];
   wire seq_last = seq_i_q == seq_len - 3'h1;
   wire load_here = valid_q[idx_q];
   // byte being offered and whether a strobe cycle runs
   wire in_seq = state_q == PMFW_SEQ;
   wire in_load = state_q == PMFW_LOAD;
   wire in_rd = state_q == PMFW_POLL || state_q == PMFW_RD;
   wire cyc_act = in_seq || (in_load && load_here) || in_rd;
   wire [15:0] cur_addr = in_seq ? seq_ent[23:8] : in_load ? {page_q, idx_q} :
                          (state_q == PMFW_RD) ? rd_addr_q : last_addr_q;
   wire [7:0] cur_data = in_seq ? seq_ent[7:0] : buf_q[idx_q];
   wire cyc_end = cyc_act && ph_q == PH_LAST;
   // completion checks on the sampled status byte
   wire poll_ok = rd_byte_q[7] == last_data_q[7];
   wire tog_ok = have_prev_q && rd_byte_q[6] == tog_prev_q;
   wire stat_ok = (op_q == PMFW_OP_WRITE) ? poll_ok : tog_ok;

   // flash pins, registered from phase so no decode glitch reaches them
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         byte_space_select_n <= 1'b1;
         wr_n <= 1'b1;
         rd_n <= 1'b1;
         flash_addr <= 16'h0000;
         flash_dq_o <= 8'h00;
         flash_dq_oe <= 1'b0;
      end else begin
         byte_space_select_n <= !(cyc_act && ph_q != PH_LAST);
         // write strobe two cycles wide, well above the glitch filter
         wr_n <= !(cyc_act && !in_rd && (ph_q == 3'h1 || ph_q == 3'h2));
         // read strobe never overlaps a write strobe
         rd_n <= !(cyc_act && in_rd && (ph_q == 3'h1 || ph_q == 3'h2));
         if (cyc_act && ph_q == 3'h0) begin
            flash_addr <= cur_addr;
            flash_dq_o <= cur_data;
         end
         // data held one cycle past the strobe rise
         flash_dq_oe <= cyc_act && !in_rd && ph_q != PH_LAST;
      end
   end

   // phase counter and byte bookkeeping
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ph_q <= 3'h0;
         last_addr_q <= 16'h0000;
         last_data_q <= 8'h00;
         rd_byte_q <= 8'h00;
      end else begin
         ph_q <= (!cyc_act || cyc_end) ? 3'h0 : ph_q + 3'h1;
         if (cyc_act && ph_q == PH_SAMPLE && in_rd) rd_byte_q <= flash_dq_i;
         if (cyc_act && !in_rd && ph_q == 3'h0) begin
            last_addr_q <= cur_addr;
            last_data_q <= cur_data;
         end
      end
   end

   // main state machine
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= PMFW_IDLE;
         op_q <= PMFW_OP_WRITE;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         prot_q <= 1'b0; // device ships unprotected
         seq_i_q <= 3'h0;
         idx_q <= 7'h00;
         tmr_q <= 20'h0_0000;
         conf_q <= 2'h0;
         tog_prev_q <= 1'b0;
         have_prev_q <= 1'b0;
      end else begin
         case (state_q)
            PMFW_IDLE: begin
               seq_i_q <= 3'h0;
               idx_q <= 7'h00;
               tmr_q <= 20'h0_0000;
               conf_q <= 2'h0;
               have_prev_q <= 1'b0;
               if (go_write) begin
                  op_q <= PMFW_OP_WRITE;
                  done_q <= 1'b0;
                  // an empty page would launch nothing
                  fail_q <= ~|valid_q;
                  busy_q <= |valid_q;
                  // protected device needs the prefix
                  state_q <= ~|valid_q ? PMFW_IDLE :
                             (use_prot_q || prot_q) ? PMFW_SEQ : PMFW_LOAD;
               end else if (go_erase || go_unprot) begin
                  op_q <= go_erase ? PMFW_OP_ERASE : PMFW_OP_UNPROT;
                  done_q <= 1'b0;
                  fail_q <= 1'b0;
                  busy_q <= 1'b1;
                  state_q <= PMFW_SEQ;
               end else if (go_read) begin
                  op_q <= PMFW_OP_READ;
                  busy_q <= 1'b1;
                  state_q <= PMFW_RD;
               end
            end
            PMFW_SEQ: if (cyc_end) begin
               seq_i_q <= seq_i_q + 3'h1;
               if (seq_last) state_q <= (op_q == PMFW_OP_WRITE) ? PMFW_LOAD : PMFW_WAIT;
            end
            // bytes follow each other within 132 cycles, far inside the window
            PMFW_LOAD: if (!load_here || cyc_end) begin
               idx_q <= idx_q + 7'h01;
               if (idx_q == 7'(PAGE_BYTES - 1)) state_q <= PMFW_WAIT;
            end
            // quiet gap lets the load window expire and the write launch
            PMFW_WAIT: begin
               tmr_q <= tmr_q + 20'h0_0001;
               if (tmr_q == 20'(BLCO_WAIT)) state_q <= PMFW_POLL;
            end
            // status reads only until the launched cycle finishes
            PMFW_POLL: begin
               tmr_q <= tmr_q + 20'h0_0001;
               if (cyc_end) begin
                  tog_prev_q <= rd_byte_q[6];
                  have_prev_q <= 1'b1;
                  conf_q <= stat_ok ? conf_q + 2'h1 : 2'h0;
                  // one good read plus two confirming ones
                  if (stat_ok && conf_q == 2'(CONFIRM_READS)) begin
                     state_q <= PMFW_IDLE;
                     busy_q <= 1'b0;
                     done_q <= 1'b1;
                     // protection state is global to the array
                     if (op_q == PMFW_OP_UNPROT) prot_q <= 1'b0;
                     else if (op_q == PMFW_OP_WRITE && use_prot_q) prot_q <= 1'b1;
                  end
               end
               // a refused write leaves the device dark or stuck
               if (tmr_q == 20'(WRITE_LIMIT)) begin
                  state_q <= PMFW_IDLE;
                  busy_q <= 1'b0;
                  fail_q <= 1'b1;
               end
            end
            PMFW_RD: if (cyc_end) begin
               state_q <= PMFW_IDLE;
               busy_q <= 1'b0;
            end
            default: state_q <= PMFW_IDLE;
         endcase
      end
   end
endmodule : pmfw_ctrl
`default_nettype wire

// ===== bench/pmfw_checker.sv
// concurrent checks on the flash strobe side of the write controller
`timescale 1ns/1ps
`default_nettype none
module pmfw_checker #(
   parameter int BLCO_WAIT = 40
) (
   input wire logic clk, // clock
   input wire logic rst, // async reset
   input wire logic byte_space_select_n, // select
   input wire logic wr_n, // write strobe
   input wire logic rd_n, // read strobe
   input wire logic [15:0] flash_addr, // address
   input wire logic [7:0] flash_dq_o, // write data
   input wire logic flash_dq_oe // data enable
);
   logic [15:0] gap_q;
   logic [15:0] gap_d;
   //////////////////////////////////////////////////////////////////////////////
   // cycles since the write strobe was last low, saturating
   assign gap_d = !wr_n ? 16'h0000 : gap_q + {15'h0000, gap_q != 16'hffff};
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gap_q <= 16'hffff;
      end else begin
         gap_q <= gap_d;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   //////////////////////////////////////////////////////////////////////////////
   // strobe shape, bus ownership and load termination
   addr_setup_a: assert property ($fell(wr_n) |-> !$past(byte_space_select_n) && $stable(flash_addr))
      else $error("address or select not settled at write strobe");
   addr_hold_a: assert property (!byte_space_select_n && !$past(byte_space_select_n) |-> $stable(flash_addr))
      else $error("address moved while selected");
   data_hold_a: assert property ($rose(wr_n) |-> flash_dq_oe && $stable(flash_dq_o))
      else $error("write data not held at strobe release");
   sel_release_a: assert property ($rose(wr_n) |-> !byte_space_select_n ##1 byte_space_select_n && !flash_dq_oe)
      else $error("select released out of order");
   wr_width_a: assert property ($fell(wr_n) |=> !wr_n ##1 wr_n)
      else $error("write strobe not two cycles low");
   rd_width_a: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n)
      else $error("read strobe not two cycles low");
   no_wr_read_a: assert property (!rd_n |-> wr_n && !flash_dq_oe && !byte_space_select_n)
      else $error("read overlaps write or drive");
   idle_pins_a: assert property (byte_space_select_n |-> wr_n && rd_n && !flash_dq_oe)
      else $error("strobe or drive while deselected");
   load_end_a: assert property ($fell(rd_n) |-> gap_q >= 16'(BLCO_WAIT - 2))
      else $error("read before page load timed out");
endmodule : pmfw_checker
bind pmfw_ctrl pmfw_checker #(.BLCO_WAIT(BLCO_WAIT)) u_checker (.clk, .rst,
   .byte_space_select_n, .wr_n, .rd_n, .flash_addr, .flash_dq_o, .flash_dq_oe);
`default_nettype wire

// ===== bench/pmfw_flash_model.sv
// behavioural page-mode flash on the byte-memory strobes
`timescale 1ns/1ps
`default_nettype none
module pmfw_flash_model #(
   parameter logic [71:0] PROT_SEQ = 72'h0,
   parameter logic [143:0] UNPROT_SEQ = 144'h0,
   parameter logic [143:0] ERASE_SEQ = 144'h0,
   parameter int BLCO_NS = 800,
   parameter int WRITE_NS = 4000,
   parameter int LOCK_NS = 1200
) (
   input wire logic byte_space_select_n, // select
   input wire logic wr_n, // write strobe
   input wire logic rd_n, // read strobe
   input wire logic [15:0] flash_addr, // address
   input wire logic [7:0] dq, // resolved bus
   output logic [7:0] dev_dq // driven data
);
   logic [7:0] mem [int];
   logic [23:0] q [$];
   logic [23:0] lst = '0;
   logic [15:0] a_l = '0;
   logic [7:0] rd_v = '0;
   logic busy = 0, prot = 0, tog = 1;
   realtime t_rise = 0, t_last = 0;
   // strict compares keep unknown pins before reset from faking a strobe edge
   wire w = byte_space_select_n === 1'b0 && wr_n === 1'b0 && rd_n === 1'b1;
   wire r = byte_space_select_n === 1'b0 && rd_n === 1'b0;
   function automatic bit seq_hit(logic [143:0] s, int n);
      seq_hit = q.size() >= n;
      for (int i = 0; i < n && seq_hit; i++) seq_hit = q[i] === s[i*24 +: 24];
   endfunction : seq_hit
   task automatic page_write();
      if (q.size() == 0) return;
      for (int i = 0; i < 128; i++) mem[{lst[23:15], 7'(i)}] = 8'hff;
      foreach (q[i]) mem[{lst[23:15], q[i][14:8]}] = q[i][7:0];
   endtask : page_write
   //////////////////////////////////////////////////////////////////////////////
   // address at the later falling edge, data at the first rising edge
   always @(posedge w) begin
      a_l = flash_addr;
      t_rise = $realtime;
   end
   always @(negedge w) begin
      if (!busy && $realtime - t_rise >= 5.0) begin
         q.push_back({a_l, dq});
         t_last = $realtime;
      end
   end
   // load timeout, sequence decode, then the timed internal cycle
   initial forever begin
      while (q.size() == 0) #40;
      while ($realtime - t_last < BLCO_NS) #10;
      busy = 1;
      tog = 1;
      lst = q[$];
      if (seq_hit(UNPROT_SEQ, 6) && q.size() == 6) prot = 0;
      else if (seq_hit(ERASE_SEQ, 6) && q.size() == 6) mem.delete();
      else if (seq_hit({72'h0, PROT_SEQ}, 3)) begin
         prot = 1;
         repeat (3) void'(q.pop_front());
         page_write();
      end else if (prot) #(LOCK_NS);
      else page_write();
      q.delete();
      #(WRITE_NS);
      busy = 0;
   end
   // status bits while busy, array data once idle
   always @(posedge r) begin
      if (busy) begin
         rd_v = {~lst[7], tog, lst[5:0]};
         tog = ~tog;
      end else rd_v = mem.exists(flash_addr) ? mem[flash_addr] : 8'hff;
   end
   assign dev_dq = r ? rd_v : ~rd_v;
endmodule : pmfw_flash_model
`default_nettype wire

// ===== bench/test_page_mode_flash_write_control.sv
// self-checking bench for the page-mode flash write controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin num_checks++; if ((s) !== (e)) begin fails++; \
   $display("unexpected %s exp %h seen %h", nm, e, s); end end
module test_page_mode_flash_write_control;
   import pmfw_pkg::*;
   localparam logic [71:0] PSEQ = 72'h1c_335e_2b22_a33a_115c;
   localparam logic [143:0] USEQ = 144'h4d44_7e5d_55a1_6e66_b27f_77c4_1188_9d22_99e6;
   localparam logic [143:0] ESEQ = 144'h0a10_3f0b_2049_0c30_5a0d_406b_0e50_7c0f_608d;
   logic clk = 0, rst = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic byte_space_select_n, wr_n, rd_n, flash_dq_oe;
   logic [15:0] flash_addr;
   logic [7:0] flash_dq_o, flash_dq_i, dev_dq;
   logic [7:0] exp_mem [int];
   logic [8:0] last_pg;
   int fails = 0, num_checks = 0;
   assign hready = hreadyout;
   assign flash_dq_i = flash_dq_oe ? flash_dq_o : dev_dq;
   always #20 clk = ~clk;
   pmfw_ctrl #(.BLCO_WAIT(200), .WRITE_LIMIT(2000), .PROT_SEQ(PSEQ), .UNPROT_SEQ(USEQ),
      .ERASE_SEQ(ESEQ)) dut (.clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hrdata, .hresp, .byte_space_select_n, .wr_n, .rd_n, .flash_addr,
      .flash_dq_o, .flash_dq_oe, .flash_dq_i);
   // load window wider than the longest scan gap between loaded bytes
   pmfw_flash_model #(.PROT_SEQ(PSEQ), .UNPROT_SEQ(USEQ), .ERASE_SEQ(ESEQ),
      .BLCO_NS(6000)) u_flash (.byte_space_select_n, .wr_n, .rd_n, .flash_addr,
      .dq(flash_dq_i), .dev_dq);
   //////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   // one single-word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] off, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      hsel <= 1'b1;
      haddr <= {24'h00_0000, off};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= 3'b010;
      for (n = 0; n == 0 || (hready !== 1'b1 && n < 50); n++) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      for (int k = 0; k == 0 || (hready !== 1'b1 && n < 100); k++, n++) @(posedge clk);
      r = hrdata;
      if (n >= 50) begin fails++; stop_test(); end
   endtask : bus
   // poll status until the operation is over
   task automatic wait_idle(output logic [31:0] s);
      int n;
      for (n = 0; n < 4000; n++) begin
         bus(1'b0, OFF_STAT, '0, s);
         if (n > 0 && s[STAT_BUSY] === 1'b0) break;
      end
      if (n >= 4000) begin fails++; stop_test(); end
   endtask : wait_idle
   task automatic check_page(input logic [8:0] pg);
      logic [31:0] s;
      logic [7:0] e;
      for (int i = 0; i < PAGE_BYTES; i++) begin
         bus(1'b1, OFF_READ, {16'h0000, pg, 7'(i)}, s);
         wait_idle(s);
         e = exp_mem.exists({pg, 7'(i)}) ? exp_mem[{pg, 7'(i)}] : ERASED_BYTE;
         `CHK("array byte", e, s[STAT_RDATA +: 8])
      end
   endtask : check_page
   // load n bytes into a random page, write it, read it all back
   task automatic page_test(input logic p, input int n, output logic [31:0] s);
      logic [7:0] b;
      logic [6:0] off;
      last_pg = 9'($urandom);
      bus(1'b1, OFF_CTRL, 32'(p) << CTRL_USE_PROT, s);
      bus(1'b1, OFF_PAGE, {23'h00_0000, last_pg}, s);
      for (int i = 0; i < PAGE_BYTES; i++) exp_mem[{last_pg, 7'(i)}] = ERASED_BYTE;
      for (int i = 0; i < n; i++) begin
         off = (n == PAGE_BYTES) ? 7'(i) : 7'($urandom);
         b = 8'($urandom);
         bus(1'b1, OFF_LOAD, {16'h0000, b, 1'b0, off}, s);
         exp_mem[{last_pg, off}] = b;
      end
      bus(1'b1, OFF_LOAD, {16'h0000, ~b, 1'b0, off}, s);
      exp_mem[{last_pg, off}] = ~b;
      bus(1'b1, OFF_CTRL, (32'(p) << CTRL_USE_PROT) | 32'h0000_0001, s);
      wait_idle(s);
      `CHK("write status", 2'b01, {s[STAT_FAIL], s[STAT_DONE]})
      check_page(last_pg);
      $display("page test of %0d bytes done", n);
   endtask : page_test
   //////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] s;
      void'($urandom(32'h59bf));
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      // unmapped read, idle pins, write with nothing loaded
      bus(1'b0, 8'h20, '0, s);
      `CHK("unmapped read", 32'h0000_0000, s)
      `CHK("idle pins", 5'b11100, {byte_space_select_n, wr_n, rd_n, flash_dq_oe, hresp})
      bus(1'b1, OFF_CTRL, 32'h0000_0001, s);
      wait_idle(s);
      `CHK("empty write", 1'b1, s[STAT_FAIL])
      $display("refusal test done");
      // full page, then one byte with protection, then a protected write
      page_test(1'b0, PAGE_BYTES, s);
      `CHK("protect flag", 1'b0, s[STAT_PROT])
      page_test(1'b1, 1, s);
      `CHK("protect flag", 1'b1, s[STAT_PROT])
      page_test(1'b0, 5, s);
      `CHK("protect flag", 1'b1, s[STAT_PROT])
      // unprotect, then a plain write must land
      bus(1'b1, OFF_CTRL, 32'h0000_0004, s);
      wait_idle(s);
      `CHK("unprotect", 3'b001, {s[STAT_PROT], s[STAT_FAIL], s[STAT_DONE]})
      page_test(1'b0, 3, s);
      // chip erase leaves the last written page erased
      bus(1'b1, OFF_CTRL, 32'h0000_0002, s);
      bus(1'b1, OFF_PAGE, {23'h00_0000, ~last_pg}, s);
      wait_idle(s);
      `CHK("erase", 2'b01, {s[STAT_FAIL], s[STAT_DONE]})
      bus(1'b0, OFF_PAGE, '0, s);
      `CHK("page while busy", {23'h00_0000, last_pg}, s)
      exp_mem.delete();
      check_page(last_pg);
      $display("erase test done");
      stop_test();
   end
endmodule : test_page_mode_flash_write_control
`default_nettype wire
